//--- hdl/system_tick_timer.sv
// System tick down counter with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "tick_params.svh"
module system_tick_timer #(
  parameter bit HAS_REF_CLK = 1'b1 // Reference clock present
) (
  input wire logic hclk, // core clock, 125 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  input wire tick_pkg::word_t hwdata, // write data
  output tick_pkg::word_t hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  input wire logic ref_clk_pin, // external reference clock
  output logic tick_pend, // one-cycle exception pend pulse
  output logic irq // level interrupt
);
  import tick_pkg::*;

  ref_tick_if ref_link ();

  ref_tick_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ref_clk_pin(ref_clk_pin),
    .tick_out(ref_link.source)
  );

  // Address phase capture
  logic aphase_q, aphase_d;
  logic awrite_q, awrite_d;
  logic [`TICK_ADDR_BITS-1:0] aaddr_q, aaddr_d;

  // Register state
  logic enable_q, enable_d;
  logic exc_en_q, exc_en_d;
  logic clksel_q, clksel_d;
  logic flag_q, flag_d;
  count_t reload_q, reload_d;
  count_t current_q, current_d;
  logic [`TICK_IRQ_BITS-1:0] irq_stat_q, irq_stat_d;
  logic [`TICK_IRQ_BITS-1:0] irq_mask_q, irq_mask_d;
  word_t hrdata_q, hrdata_d;
  logic pend_q, pend_d;
  logic irq_q, irq_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q, hresp_d;

  logic take;
  logic wr_csr, wr_reload, wr_current, wr_mask;
  logic rd_csr, rd_status;
  logic src_tick, wrap_event;
  logic [`TICK_ADDR_BITS-1:0] rd_addr;

  // Single-word transfers only; every access answers with no wait state
  assign take = hsel & hready & htrans[1];

  always_comb
  begin
    aphase_d = take;
    awrite_d = take & hwrite;
    aaddr_d = take ? haddr[`TICK_ADDR_BITS-1:0] : aaddr_q;
  end

  always_comb
  begin
    wr_csr = aphase_q & awrite_q & (aaddr_q == `TICK_CSR_OFFSET);
    wr_reload = aphase_q & awrite_q & (aaddr_q == `TICK_RELOAD_OFFSET);
    wr_current = aphase_q & awrite_q & (aaddr_q == `TICK_CURRENT_OFFSET);
    wr_mask = aphase_q & awrite_q & (aaddr_q == `TICK_IRQ_MASK_OFFSET);
    rd_addr = haddr[`TICK_ADDR_BITS-1:0];
    // Read side effects act when the read data is captured
    rd_csr = take & ~hwrite & (rd_addr == `TICK_CSR_OFFSET);
    rd_status = take & ~hwrite & (rd_addr == `TICK_IRQ_STATUS_OFFSET);
  end

  // Source tick: core clock every cycle, reference clock on its rising edges
  always_comb
  begin
    src_tick = clksel_q ? 1'b1 : ref_link.tick;
  end

  always_comb
  begin
    enable_d = enable_q;
    exc_en_d = exc_en_q;
    clksel_d = clksel_q;
    reload_d = reload_q;
    current_d = current_q;
    wrap_event = 1'b0;
    if (wr_csr)
    begin
      enable_d = hwdata[`TICK_ENABLE_BIT];
      exc_en_d = hwdata[`TICK_EXC_EN_BIT];
      // Select bit sticks at core clock without a reference source
      clksel_d = HAS_REF_CLK ? hwdata[`TICK_CLKSEL_BIT] : 1'b1;
    end
    if (wr_reload)
    begin
      reload_d = hwdata[`TICK_CNT_BITS-1:0];
    end
    if (wr_current)
    begin
      // Write clear wins over a tick and raises no wrap event
      current_d = `TICK_CNT_RESET;
    end
    else if (enable_q && src_tick)
    begin
      if (current_q == `TICK_CNT_RESET)
      begin
        current_d = reload_q;
      end
      else
      begin
        current_d = current_q - 24'h00_0001;
        wrap_event = (current_q == 24'h00_0001);
      end
    end
  end

  always_comb
  begin
    // Set wins over clear in the same cycle
    flag_d = flag_q;
    if (rd_csr || wr_current)
    begin
      flag_d = 1'b0;
    end
    if (wrap_event)
    begin
      flag_d = 1'b1;
    end
    irq_stat_d = irq_stat_q;
    if (rd_status)
    begin
      irq_stat_d = '0;
    end
    if (wrap_event)
    begin
      irq_stat_d[`TICK_IRQ_WRAP_BIT] = 1'b1;
    end
    irq_mask_d = wr_mask ? hwdata[`TICK_IRQ_BITS-1:0] : irq_mask_q;
    pend_d = wrap_event & exc_en_q;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_comb
  begin
    hrdata_d = hrdata_q;
    if (take && !hwrite)
    begin
      hrdata_d = 32'h0000_0000;
      case (rd_addr)
        `TICK_CSR_OFFSET:
        begin
          hrdata_d[`TICK_ENABLE_BIT] = enable_q;
          hrdata_d[`TICK_EXC_EN_BIT] = exc_en_q;
          hrdata_d[`TICK_CLKSEL_BIT] = clksel_q;
          hrdata_d[`TICK_FLAG_BIT] = flag_q;
        end
        `TICK_RELOAD_OFFSET:
        begin
          hrdata_d[`TICK_CNT_BITS-1:0] = reload_q;
        end
        `TICK_CURRENT_OFFSET:
        begin
          hrdata_d[`TICK_CNT_BITS-1:0] = current_q;
        end
        `TICK_IRQ_STATUS_OFFSET:
        begin
          hrdata_d[`TICK_IRQ_BITS-1:0] = irq_stat_q;
        end
        `TICK_IRQ_MASK_OFFSET:
        begin
          hrdata_d[`TICK_IRQ_BITS-1:0] = irq_mask_q;
        end
        default:
        begin
          // Unmapped addresses read as zero
          hrdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registered even though constant, so every bus output leaves a flop
  always_comb
  begin
    hreadyout_d = 1'b1;
    hresp_d = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aphase_q <= 1'b0;
      awrite_q <= 1'b0;
      aaddr_q <= '0;
    end
    else
    begin
      aphase_q <= aphase_d;
      awrite_q <= awrite_d;
      aaddr_q <= aaddr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_q <= 1'b0;
      exc_en_q <= 1'b0;
      // Control word resets to zero (reference clock) when one is fitted, else the select bit resets to core clock
      clksel_q <= HAS_REF_CLK ? 1'b0 : 1'b1;
      reload_q <= `TICK_CNT_RESET;
      current_q <= `TICK_CNT_RESET;
    end
    else
    begin
      enable_q <= enable_d;
      exc_en_q <= exc_en_d;
      clksel_q <= clksel_d;
      reload_q <= reload_d;
      current_q <= current_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_q <= 1'b0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      hrdata_q <= hrdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      hreadyout_q <= hreadyout_d;
      hresp_q <= hresp_d;
    end
  end

  // Zero wait states: ready stays high and the response stays OKAY
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign tick_pend = pend_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

//--- hdl/tick_params.svh
// Offsets, field positions, reset values and widths of the tick timer
`ifndef TICK_PARAMS_SVH
`define TICK_PARAMS_SVH
`define TICK_CSR_OFFSET 12'h010
`define TICK_RELOAD_OFFSET 12'h014
`define TICK_CURRENT_OFFSET 12'h018
`define TICK_IRQ_STATUS_OFFSET 12'h020
`define TICK_IRQ_MASK_OFFSET 12'h024
`define TICK_ADDR_BITS 12
`define TICK_CNT_BITS 24
`define TICK_ENABLE_BIT 0
`define TICK_EXC_EN_BIT 1
`define TICK_CLKSEL_BIT 2
`define TICK_FLAG_BIT 16
`define TICK_CSR_RESET 32'h0000_0000
`define TICK_CNT_RESET 24'h00_0000
`define TICK_IRQ_WRAP_BIT 0
`define TICK_IRQ_BITS 1
`endif

//--- hdl/tick_pkg.sv
// Types shared by the tick timer modules
package tick_pkg;
  typedef logic [23:0] count_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } bus_state_t;
endpackage

//--- hdl/ref_tick_if.sv
// Reference clock tick enable carried from the synchroniser to the timer
`timescale 1ns/100ps
`default_nettype none
interface ref_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface
`default_nettype wire

//--- hdl/ref_tick_sync.sv
// Synchronises the external reference clock and makes a one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module ref_tick_sync (
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset, active low
  input wire logic ref_clk_pin, // external reference clock level
  ref_tick_if.source tick_out // tick on each reference rising edge
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;
  logic tick_q, tick_d;

  always_comb
  begin
    meta_d = ref_clk_pin;
    sync_d = meta_q;
    last_d = sync_q;
    // Edge detect compares the second stage with the third, never the first
    tick_d = sync_q & ~last_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out.tick = tick_q;
endmodule
`default_nettype wire

//--- sim/tick_checker.sv
// Port-level assertions for the tick timer
`timescale 1ns/100ps
`default_nettype none
module tick_checker (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire tick_pkg::word_t hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic tick_pend, // pend pulse
  input wire logic irq // interrupt
);
  import tick_pkg::*;
  logic [1:0] clr_q;
  logic take;
  logic rd;
  assign take = hsel & hready & htrans[1];
  assign rd = take & !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Window in which an irq status read or mask write may drop irq
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      clr_q <= 2'h0;
    else if (take && haddr[11:0] == (hwrite ? 12'h024 : 12'h020))
      clr_q <= 2'h3;
    else if (clr_q != 2'h0)
      clr_q <= clr_q - 2'h1;
  // Address phases of the read kinds whose data phase is judged
  sequence read_unmapped;
    rd && !(haddr[11:0] inside {12'h010, 12'h014, 12'h018, 12'h020,
    12'h024});
  endsequence
  sequence read_ctl;
    rd && haddr[11:0] == 12'h010;
  endsequence
  sequence read_count;
    rd && haddr[11:0] inside {12'h014, 12'h018};
  endsequence
  a_ready_high: assert property (hreadyout) else $error("ready low");
  a_resp_okay: assert property (!hresp) else $error("resp not okay");
  a_pend_single: assert property (
    tick_pend |=> !tick_pend) else $error("pend too long");
  a_unmapped_zero: assert property (
    read_unmapped |=> hrdata == 32'h0) else $error("unmapped data");
  a_ctl_reserved: assert property (
    read_ctl |=> hrdata[31:17] == 15'h0
    && hrdata[15:3] == 13'h0) else $error("ctl reserved set");
  a_count_reserved: assert property (
    read_count |=> hrdata[31:24] == 8'h0) else $error("count reserved set");
  a_rdata_hold: assert property (
    !rd |=> $stable(hrdata)) else $error("read data moved");
  a_irq_clear: assert property (
    $fell(irq) |-> clr_q != 2'h0) else $error("irq fell unasked");
endmodule
bind system_tick_timer tick_checker i_tick_checker (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .tick_pend, .irq);
`default_nettype wire

//--- sim/core_model.sv
// Core side: counts tick pends and makes reference clock bursts
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic hclk, // core clock
  input wire logic tick_pend, // pend request
  output logic ref_clk_pin // reference clock, still between bursts
);
  int n_pend = 0;
  int gap = 0;
  int cyc = 0;
  int last = 0;
  initial ref_clk_pin = 1'b0;
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (tick_pend)
    begin
      n_pend <= n_pend + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  task automatic ref_pulses(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge hclk);
      ref_clk_pin <= 1'b1;
      repeat (6) @(posedge hclk);
      ref_clk_pin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- sim/system_tick_timer_bench.sv
// Self-checking bench for the tick timer
`timescale 1ns/100ps
`default_nettype none
`include "tick_params.svh"
module system_tick_timer_bench;
  import tick_pkg::*;
  localparam logic [11:0] ctl = `TICK_CSR_OFFSET;
  localparam logic [11:0] rld = `TICK_RELOAD_OFFSET;
  localparam logic [11:0] cur = `TICK_CURRENT_OFFSET;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  word_t hwdata = 32'h0;
  word_t hrdata;
  logic hreadyout, hresp, ref_clk_pin, tick_pend, irq;
  int n_fail = 0;
  int checks = 0;
  always #4 hclk = ~hclk;
  system_tick_timer i_system_tick_timer (.hclk, .hresetn, .hsel(1'b1),
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .ref_clk_pin, .tick_pend, .irq);
  core_model i_core_model (.hclk, .tick_pend, .ref_clk_pin);
  task automatic chk(input word_t got, input word_t exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input word_t d,
    output word_t r);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input word_t d);
    word_t r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input word_t exp);
    word_t r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic t_regs;
    rd(ctl, 32'h0);
    wr(ctl, 32'hFFFF_FFF8);
    rd(ctl, 32'h0);
    wr(rld, 32'hFFFF_FFFF);
    rd(rld, 32'h00FF_FFFF);
    rd(12'h030, 32'h0);
  endtask
  task automatic t_wrap;
    wr(rld, 32'h4);
    wr(cur, 32'h0);
    wr(ctl, 32'h7);
    repeat (30) @(posedge hclk);
    chk(i_core_model.gap, 32'h5);
    wr(ctl, 32'h6);
    repeat (2) @(posedge hclk);
    rd(ctl, 32'h0001_0006);
    rd(ctl, 32'h6);
    wr(`TICK_IRQ_MASK_OFFSET, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    rd(`TICK_IRQ_STATUS_OFFSET, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_zero;
    int p;
    wr(rld, 32'h0);
    wr(cur, 32'h55);
    rd(cur, 32'h0);
    p = i_core_model.n_pend;
    wr(ctl, 32'h7);
    repeat (20) @(posedge hclk);
    rd(cur, 32'h0);
    rd(ctl, 32'h7);
    chk(i_core_model.n_pend, p);
  endtask
  task automatic t_ref;
    int p;
    // Leave the core clock first so the new reload is not taken at once
    wr(ctl, 32'h3);
    wr(rld, 32'h64);
    repeat (10) @(posedge hclk);
    rd(cur, 32'h0);
    i_core_model.ref_pulses(5);
    repeat (8) @(posedge hclk);
    rd(cur, 32'h60);
    rd(ctl, 32'h3);
    p = i_core_model.n_pend;
    wr(cur, 32'h1);
    repeat (4) @(posedge hclk);
    chk(i_core_model.n_pend, p);
    rd(ctl, 32'h3);
  endtask
  task automatic t_noexc;
    int p;
    wr(rld, 32'h2);
    p = i_core_model.n_pend;
    wr(ctl, 32'h5);
    repeat (20) @(posedge hclk);
    chk(i_core_model.n_pend, p);
    rd(ctl, 32'h0001_0005);
    wr(ctl, 32'h4);
    wr(cur, 32'h0);
    repeat (5) @(posedge hclk);
    rd(cur, 32'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_wrap();
    t_zero();
    t_ref();
    t_noexc();
    stop_test();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
